// file: inc/elc_defines.vh
// Constants for the serial EEPROM lock and status controller.
// Assumes a 100 MHz system clock; included by the top-level design file by bare name.
`ifndef ELC_DEFINES_VH
`define ELC_DEFINES_VH
`define ELC_DEV_ARRAY 7'h50
`define ELC_DEV_CSR 7'h52
`define ELC_CSR_ADDR 8'hFF
`define ELC_CSR_RESET 8'h00
`define ELC_BIT_LOCK_HI 4
`define ELC_BIT_LOCK_LO 3
`define ELC_BIT_REG_WRITE_ENABLE_LATCH 2
`define ELC_BIT_WEL 1
`define ELC_CSR_SET_WEL 8'h02
`define ELC_CSR_CLR_WEL 8'h00
`define ELC_CSR_SET_REG_WRITE_ENABLE_LATCH 8'h06
`define ELC_LOCK_Q1_BASE 8'hC0
`define ELC_LOCK_HALF_BASE 8'h80
`define ELC_NV_CYCLE_MS 5
`define ELC_CLK_MHZ 100
`define ELC_NV_CYCLE_CLKS (`ELC_NV_CYCLE_MS * 1000 * `ELC_CLK_MHZ)
`endif

// file: hw/elc_mem.v
// Holds the 256-byte array contents with registered read data.
// Assumes the caller serialises reads and writes on the same clock.
`timescale 1ns/100ps
module elc_mem (
    input wire i_clk,
    input wire i_ce,
    input wire i_we,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata
);
    reg [7:0] mem [0:255];

    always @(posedge i_clk) begin
        if (i_ce) begin
            if (i_we) begin
                mem[i_addr] <= i_wdata;
            end
            o_rdata <= mem[i_addr];
        end
    end
endmodule // elc_mem

// file: hw/elc_top.v
// Two-wire slave: sequential array reads, array byte write, control/status register.
// Assumes SCL and SDA are asynchronous pins; SDA is open drain driven via o_sda_oe.
//
// Behaviour
// - Sequential read starts from current-address or random-address read.
// - Each master acknowledge fetches another byte; NACK then STOP ends it.
// - Read address increments per byte and wraps from FFh to 00h.
// - Status register: bits 4,3 lock select, bit 2 reg latch, bit 1 latch.
// - Volatile bits clear at power-up; lock bits kept across power cycles.
// - Clear write enable latch aborts writes and withholds data-byte acknowledge.
// - Writing 02h sets write enable latch; writing 00h clears it.
// - Latch-only writes start no cycle; next operation accepted at once.
// - Other bits need reg latch; reg latch needs write enable latch set.
// - Reg latch clears after register write and on locked-array write attempt.
// - Lock 00 none, 01 C0h-FFh, 10 80h-FFh, 11 everything.
// - Writes to locked addresses are aborted; array unchanged.
// - Any nonzero lock bit refuses wiper writes.
// - Lock bits default to zero as shipped.
// - Write-protect pin high blocks nonvolatile array and wiper writes.
// - Write-protect pin high ignores writes to nonvolatile register bits.
// - Second data byte in register write gets no acknowledge; write aborts.
// - STOP after valid register byte starts timed cycle storing lock bits.
// - Bit 2 set in third write leaves reg latch set, lock bits unchanged.
// - During internal cycle all bus requests ignored, SDA released.
// - Register read via dummy write to FFh; one byte per read.
`timescale 1ns/100ps
`include "elc_defines.vh"
module elc_top #(
    parameter NV_CYCLE_CLKS = `ELC_NV_CYCLE_CLKS
) (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_ce,
    input wire i_scl,
    input wire i_sda,
    input wire i_wp,
    input wire [1:0] i_nv_lock,
    output reg o_sda_oe,
    output wire o_sda_o,
    output wire o_busy,
    output wire [7:0] o_control_status_reg,
    output reg o_pot_write_allowed,
    output wire [1:0] o_nv_lock
);
    localparam S_IDLE = 7'h01;
    localparam S_DEV = 7'h02;
    localparam S_ADDR = 7'h04;
    localparam S_WDATA = 7'h08;
    localparam S_RDATA = 7'h10;
    localparam S_RACK = 7'h20;
    localparam S_IGN = 7'h40;

    reg [2:0] scl_s_q;
    reg [2:0] sda_s_q;
    reg [1:0] wp_s_q;
    reg [6:0] st_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;
    reg [7:0] tx_q;
    reg is_csr_q;
    reg is_rd_q;
    reg ack_phase_q;
    reg nack_q;
    reg [7:0] addr_q;
    reg [1:0] nbytes_q;
    reg pend_arr_q;
    reg pend_csr_q;
    reg [7:0] pend_data_q;
    reg wel_q;
    reg reg_write_enable_latch_q;
    reg [1:0] lock_q;
    reg lock_ld_q;
    reg [31:0] busy_cnt_q;
    reg mem_we;
    wire [7:0] mem_rdata;

    wire scl = scl_s_q[1];
    wire sda = sda_s_q[1];
    wire scl_rise = scl & ~scl_s_q[2];
    wire scl_fall = ~scl & scl_s_q[2];
    wire start_c = scl & scl_s_q[2] & ~sda & sda_s_q[2];
    wire stop_c = scl & scl_s_q[2] & sda & ~sda_s_q[2];
    wire wp = wp_s_q[1];
    wire busy = (busy_cnt_q != 32'h0);
    wire [7:0] rx_byte = {sh_q[6:0], sda};

    // Locked region check for the current array address.
    wire addr_locked = (lock_q == 2'b11) ||
        (lock_q == 2'b10 && addr_q >= `ELC_LOCK_HALF_BASE) ||
        (lock_q == 2'b01 && addr_q >= `ELC_LOCK_Q1_BASE);

    assign o_busy = busy;
    assign o_sda_o = 1'b0;
    assign o_nv_lock = lock_q;
    assign o_control_status_reg = {3'b000, lock_q, reg_write_enable_latch_q, wel_q, 1'b0};

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            scl_s_q <= 3'b111;
            sda_s_q <= 3'b111;
            wp_s_q <= 2'b00;
        end else if (i_ce) begin
            scl_s_q <= {scl_s_q[1:0], i_scl};
            sda_s_q <= {sda_s_q[1:0], i_sda};
            wp_s_q <= {wp_s_q[0], i_wp};
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pot_write_allowed <= 1'b0;
        end else if (i_ce) begin
            o_pot_write_allowed <= wel_q & ~wp & (lock_q == 2'b00);
        end
    end

    elc_mem u_mem (
        .i_clk(i_clk),
        .i_ce(i_ce),
        .i_we(mem_we),
        .i_addr(addr_q),
        .i_wdata(pend_data_q),
        .o_rdata(mem_rdata)
    );

    // Only the register's lock bits are nonvolatile; they come from the backing store
    // on i_nv_lock, caught one clock after reset release.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= S_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            is_csr_q <= 1'b0;
            is_rd_q <= 1'b0;
            ack_phase_q <= 1'b0;
            nack_q <= 1'b0;
            addr_q <= 8'h00;
            nbytes_q <= 2'b00;
            pend_arr_q <= 1'b0;
            pend_csr_q <= 1'b0;
            pend_data_q <= 8'h00;
            wel_q <= 1'b0;
            reg_write_enable_latch_q <= 1'b0;
            lock_q <= 2'b00;
            lock_ld_q <= 1'b1;
            busy_cnt_q <= 32'h0;
            o_sda_oe <= 1'b0;
            mem_we <= 1'b0;
        end else if (i_ce) begin
            mem_we <= 1'b0;
            if (lock_ld_q) begin
                lock_ld_q <= 1'b0;
                lock_q <= i_nv_lock;
            end
            if (busy) begin
                // Bus is deaf and SDA released until the cycle ends.
                busy_cnt_q <= busy_cnt_q - 32'h1;
                o_sda_oe <= 1'b0;
                st_q <= S_IDLE;
                if (busy_cnt_q == 32'h1 && pend_csr_q) begin
                    pend_csr_q <= 1'b0;
                    reg_write_enable_latch_q <= 1'b0;
                end
            end else if (start_c) begin
                st_q <= S_DEV;
                bit_q <= 4'h0;
                ack_phase_q <= 1'b0;
                o_sda_oe <= 1'b0;
                pend_arr_q <= 1'b0;
                pend_csr_q <= 1'b0;
                nbytes_q <= 2'b00;
            end else if (stop_c) begin
                st_q <= S_IDLE;
                o_sda_oe <= 1'b0;
                if (pend_arr_q) begin
                    pend_arr_q <= 1'b0;
                    mem_we <= 1'b1;
                    busy_cnt_q <= NV_CYCLE_CLKS;
                end else if (pend_csr_q) begin
                    if (pend_data_q == `ELC_CSR_SET_WEL) begin
                        wel_q <= 1'b1;
                        pend_csr_q <= 1'b0;
                        if (reg_write_enable_latch_q && !wp) begin
                            lock_q <= 2'b00;
                            busy_cnt_q <= NV_CYCLE_CLKS;
                            pend_csr_q <= 1'b1;
                        end
                    end else if (pend_data_q == `ELC_CSR_CLR_WEL) begin
                        wel_q <= 1'b0;
                        reg_write_enable_latch_q <= 1'b0;
                        pend_csr_q <= 1'b0;
                    end else if (pend_data_q == `ELC_CSR_SET_REG_WRITE_ENABLE_LATCH) begin
                        reg_write_enable_latch_q <= 1'b1;
                        pend_csr_q <= 1'b0;
                    end else if (reg_write_enable_latch_q && pend_data_q[`ELC_BIT_REG_WRITE_ENABLE_LATCH]) begin
                        pend_csr_q <= 1'b0;
                    end else if (reg_write_enable_latch_q && !wp) begin
                        lock_q <= {pend_data_q[`ELC_BIT_LOCK_HI],
                            pend_data_q[`ELC_BIT_LOCK_LO]};
                        busy_cnt_q <= NV_CYCLE_CLKS;
                    end else begin
                        pend_csr_q <= 1'b0;
                    end
                end
            end else if (scl_fall) begin
                if (ack_phase_q) begin
                    ack_phase_q <= 1'b0;
                    o_sda_oe <= 1'b0;
                    if (st_q == S_RDATA) begin
                        tx_q <= is_csr_q ? o_control_status_reg : mem_rdata;
                        o_sda_oe <= is_csr_q ? ~o_control_status_reg[7] : ~mem_rdata[7];
                        addr_q <= is_csr_q ? addr_q : addr_q + 8'h01;
                    end
                end else if (st_q == S_RDATA && bit_q != 4'h0 && bit_q != 4'h8) begin
                    o_sda_oe <= ~tx_q[7 - bit_q[2:0]];
                end else if (st_q == S_RDATA && bit_q == 4'h8) begin
                    o_sda_oe <= 1'b0;
                    st_q <= S_RACK;
                end else if (bit_q == 4'h8) begin
                    bit_q <= 4'h0;
                    ack_phase_q <= 1'b1;
                    o_sda_oe <= ~nack_q;
                    if (nack_q) begin
                        st_q <= S_IGN;
                        ack_phase_q <= 1'b0;
                    end else if (st_q == S_DEV && is_rd_q) begin
                        // Read data starts only once the address acknowledge is out.
                        st_q <= S_RDATA;
                    end
                end
            end else if (scl_rise && !ack_phase_q) begin
                // The acknowledge clock belongs to no byte, so it is not counted.
                case (st_q)
                    S_DEV, S_ADDR, S_WDATA: begin
                        sh_q <= rx_byte;
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h7) begin
                            nack_q <= 1'b0;
                            if (st_q == S_DEV) begin
                                is_rd_q <= sda;
                                if (rx_byte[7:1] == `ELC_DEV_CSR) begin
                                    is_csr_q <= 1'b1;
                                end else if (rx_byte[7:1] == `ELC_DEV_ARRAY) begin
                                    is_csr_q <= 1'b0;
                                end else begin
                                    nack_q <= 1'b1;
                                end
                                st_q <= sda ? S_DEV : S_ADDR;
                            end else if (st_q == S_ADDR) begin
                                addr_q <= rx_byte;
                                st_q <= S_WDATA;
                                if (is_csr_q && rx_byte != `ELC_CSR_ADDR) begin
                                    nack_q <= 1'b1;
                                end
                            end else begin
                                pend_data_q <= rx_byte;
                                nbytes_q <= nbytes_q | 2'b01;
                                if (!wel_q && !(is_csr_q && rx_byte == `ELC_CSR_SET_WEL)) begin
                                    nack_q <= 1'b1;
                                end else if (is_csr_q && nbytes_q != 2'b00) begin
                                    nack_q <= 1'b1;
                                    pend_csr_q <= 1'b0;
                                end else if (is_csr_q) begin
                                    pend_csr_q <= 1'b1;
                                end else if (wp) begin
                                    nack_q <= 1'b1;
                                end else if (addr_locked) begin
                                    nack_q <= 1'b1;
                                    reg_write_enable_latch_q <= 1'b0;
                                end else begin
                                    pend_arr_q <= 1'b1;
                                end
                            end
                        end
                    end
                    S_RDATA: begin
                        bit_q <= bit_q + 4'h1;
                    end
                    S_RACK: begin
                        // Master ACK fetches the next array byte; NACK, or any register read, waits for STOP.
                        bit_q <= 4'h0;
                        if (!sda && !is_csr_q) begin
                            st_q <= S_RDATA;
                            ack_phase_q <= 1'b1;
                        end else begin
                            st_q <= S_IGN;
                        end
                    end
                    S_IGN, S_IDLE: begin
                        bit_q <= 4'h0;
                    end
                    default: begin
                        st_q <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // elc_top

// file: sim/elc_asserts.sv
// Port-level checker for elc_top.
// Assumes it is bound to elc_top and sees its ports only.
`timescale 1ns/100ps
module elc_asserts #(
    parameter NV_CYCLE_CLKS = 50
) (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_ce,
    input wire i_scl,
    input wire i_sda,
    input wire i_wp,
    input wire [1:0] i_nv_lock,
    input wire o_sda_oe,
    input wire o_sda_o,
    input wire o_busy,
    input wire [7:0] o_control_status_reg,
    input wire o_pot_write_allowed,
    input wire [1:0] o_nv_lock
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // Counts busy cycles so the whole cycle length can be checked at its end.
    logic [31:0] cnt_q;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) cnt_q <= 32'h0;
        else cnt_q <= o_busy ? cnt_q + 32'h1 : 32'h0;
    end
    a_rsv_bits_zero: assert property (o_control_status_reg[7:5] == 3'h0 && !o_control_status_reg[0])
        else $error("reserved status bits not zero");
    a_busy_bus_quiet: assert property (o_busy |-> !o_sda_oe)
        else $error("data line driven during internal cycle");
    a_lock_no_pot: assert property ((o_nv_lock != 2'h0) [*3] |-> !o_pot_write_allowed)
        else $error("wiper write allowed while locked");
    a_wel_no_pot: assert property ((!o_control_status_reg[1]) [*3] |-> !o_pot_write_allowed)
        else $error("wiper write allowed without write enable");
    a_busy_cycle_len: assert property ($fell(o_busy) |-> cnt_q == NV_CYCLE_CLKS)
        else $error("internal cycle length wrong");
    a_reg_write_enable_latch_needs_wel: assert property (o_control_status_reg[2] |-> o_control_status_reg[1])
        else $error("register latch set without write enable");
    a_reset_vol_clear: assert property ($rose(i_arst_n) |-> o_control_status_reg[2:1] == 2'h0)
        else $error("volatile bits not cleared by reset");
    a_wp_lock_hold: assert property (i_wp [*4] |=> $stable(o_nv_lock))
        else $error("lock bits changed under write protect");
    c_busy: cover property ($fell(o_busy));
    c_ack: cover property ($rose(o_sda_oe));
    c_locked: cover property (o_nv_lock == 2'h1);
endmodule // elc_asserts
bind elc_top elc_asserts #(.NV_CYCLE_CLKS(NV_CYCLE_CLKS)) u_chk (.i_clk(i_clk),
    .i_arst_n(i_arst_n), .i_ce(i_ce), .i_scl(i_scl), .i_sda(i_sda), .i_wp(i_wp),
    .i_nv_lock(i_nv_lock), .o_sda_oe(o_sda_oe), .o_sda_o(o_sda_o), .o_busy(o_busy),
    .o_control_status_reg(o_control_status_reg),
    .o_pot_write_allowed(o_pot_write_allowed), .o_nv_lock(o_nv_lock));

// file: sim/elc_master.sv
// Behavioural two-wire bus master.
// Assumes the data line has a pull-up; the clock idles high between frames.
`timescale 1ns/100ps
module elc_master (
    output logic o_scl,
    output logic o_sda_low,
    input wire i_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        #31.25 o_sda_low = !b;
        #31.25 o_scl = 1'b1;
        #31.25 r = i_sda;
        #31.25 o_scl = 1'b0;
    endtask
    // Also serves as a repeated start when entered with the clock low; the first
    // quarter gives the slave time to release its acknowledge before the clock rises.
    task automatic start();
        #31.25 o_sda_low = 1'b0;
        #31.25 o_scl = 1'b1;
        #31.25 o_sda_low = 1'b1;
        #31.25 o_scl = 1'b0;
    endtask
    task automatic stop();
        #31.25 o_sda_low = 1'b1;
        #31.25 o_scl = 1'b1;
        #31.25 o_sda_low = 1'b0;
        #62.5;
    endtask
    // Returns the ninth bit as seen on the line; low means acknowledged.
    task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] q,
                        output logic ack_n);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(b9, ack_n);
    endtask
endmodule // elc_master

// file: sim/elc_top_test.sv
// Testbench for elc_top with a behavioural bus master.
// Assumes the lock bits are stored by the bench between resets.
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module elc_top_test;
    logic clk = 0, arst_n = 0, wp = 0;
    logic [1:0] nv = 2'h0;
    int error_cnt = 0, check_count = 0;
    wire scl, m_low, oe, sda_o, busy, pot;
    wire [7:0] cs;
    wire [1:0] nvo;
    wire sda = !(m_low | oe);
    logic a;
    logic [7:0] q, r0, r1;
    always #5 clk = !clk;
    elc_master m (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));
    elc_top #(.NV_CYCLE_CLKS(50)) dut (.i_clk(clk), .i_arst_n(arst_n), .i_ce(1'b1),
        .i_scl(scl), .i_sda(sda), .i_wp(wp), .i_nv_lock(nv), .o_sda_oe(oe),
        .o_sda_o(sda_o), .o_busy(busy), .o_control_status_reg(cs),
        .o_pot_write_allowed(pot), .o_nv_lock(nvo));
    task automatic test_done();
        if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] ad, d, output logic ak);
        m.start();
        m.xfer({dev, 1'b0}, 1'b1, q, ak);
        m.xfer(ad, 1'b1, q, ak);
        m.xfer(d, 1'b1, q, ak);
        m.stop();
        repeat (6) @(negedge clk);
    endtask
    task automatic rd(input logic [6:0] dev, input logic [7:0] ad, input int n);
        m.start();
        m.xfer({dev, 1'b0}, 1'b1, q, a);
        m.xfer(ad, 1'b1, q, a);
        m.start();
        m.xfer({dev, 1'b1}, 1'b1, q, a);
        m.xfer(8'hFF, n == 1, r0, a);
        if (n > 1) m.xfer(8'hFF, 1'b1, r1, a);
        m.stop();
    endtask
    task automatic idle();
        int k;
        for (k = 0; k < 300 && busy !== 1'b0; k++) @(negedge clk);
        if (k == 300) begin
            error_cnt++;
            test_done();
        end
    endtask
    task automatic do_reset();
        @(negedge clk) arst_n = 0;
        repeat (12) @(negedge clk);
        arst_n = 1;
        repeat (6) @(negedge clk);
    endtask
    initial begin
        do_reset();
        rd(7'h52, 8'hFF, 1);
        `CHK("csr_read", 8'h00, r0)
        wr(7'h50, 8'h10, 8'hA5, a);
        `CHK("wr_no_wel_ack", 1'b1, a)
        wr(7'h52, 8'hFF, 8'h02, a);
        `CHK("wel_ack", 1'b0, a)
        `CHK("wel_busy", 1'b0, busy)
        `CHK("wel_cs", 8'h02, cs)
        `CHK("pot_open", 1'b1, pot)
        wr(7'h50, 8'hFF, 8'h5A, a);
        `CHK("arr_busy", 1'b1, busy)
        `CHK("busy_oe", 1'b0, oe)
        `CHK("sda_o", 1'b0, sda_o)
        m.start();
        m.xfer(8'hA0, 1'b1, q, a);
        m.stop();
        `CHK("busy_ignored", 1'b1, a)
        idle();
        wr(7'h50, 8'h00, 8'hC3, a);
        idle();
        rd(7'h50, 8'hFF, 2);
        `CHK("seq_b0", 8'h5A, r0)
        `CHK("seq_wrap", 8'hC3, r1)
        wr(7'h52, 8'hFF, 8'h06, a);
        `CHK("reg_write_enable_latch_cs", 8'h06, cs)
        wr(7'h52, 8'hFF, 8'h0A, a);
        `CHK("lock_busy", 1'b1, busy)
        idle();
        `CHK("lock_cs", 8'h0A, cs)
        `CHK("lock_nv", 2'h1, nvo)
        `CHK("lock_pot", 1'b0, pot)
        wr(7'h52, 8'hFF, 8'h06, a);
        wr(7'h50, 8'hC0, 8'h11, a);
        `CHK("locked_ack", 1'b1, a)
        `CHK("locked_cs", 8'h0A, cs)
        `CHK("locked_busy", 1'b0, busy)
        wr(7'h50, 8'hBF, 8'h22, a);
        `CHK("open_ack", 1'b0, a)
        idle();
        wr(7'h52, 8'hFF, 8'h06, a);
        wr(7'h52, 8'hFF, 8'h0E, a);
        idle();
        `CHK("relatch_cs", 8'h0E, cs)
        m.start();
        m.xfer(8'hA4, 1'b1, q, a);
        m.xfer(8'hFF, 1'b1, q, a);
        m.xfer(8'h06, 1'b1, q, a);
        m.xfer(8'h06, 1'b1, q, a);
        m.stop();
        `CHK("second_byte", 1'b1, a)
        idle();
        wr(7'h52, 8'hFF, 8'h06, a);
        @(negedge clk) wp = 1;
        repeat (4) @(negedge clk);
        `CHK("wp_pot", 1'b0, pot)
        wr(7'h50, 8'h10, 8'h33, a);
        `CHK("wp_arr_ack", 1'b1, a)
        wr(7'h52, 8'hFF, 8'h02, a);
        idle();
        `CHK("wp_nv", 2'h1, nvo)
        @(negedge clk) wp = 0;
        wr(7'h52, 8'hFF, 8'h00, a);
        `CHK("wel_clr", 8'h08, cs)
        wr(7'h52, 8'hFF, 8'h06, a);
        `CHK("reg_write_enable_latch_no_wel", 1'b1, a)
        nv = nvo;
        do_reset();
        `CHK("nv_kept", 8'h08, cs)
        wr(7'h52, 8'hFF, 8'h02, a);
        wr(7'h52, 8'hFF, 8'h06, a);
        wr(7'h52, 8'hFF, 8'h02, a);
        idle();
        `CHK("unlock_cs", 8'h02, cs)
        `CHK("unlock_pot", 1'b1, pot)
        test_done();
    end
endmodule // elc_top_test
